// File: depress_pkg.sv
// Purpose: Shared constants, types and vote function for the depressurization logic.
// Assumes: One division per instance, clocked at 125 MHz.
// Notes: Delay counts are derived from the times in their own units.
`default_nettype none

package depress_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned VOTE_MIN = 2;
  localparam int unsigned LPF_PUMPS = 3;
  localparam int unsigned HPF_PUMPS = 2;
  localparam int unsigned VALVES = 8;
  localparam int unsigned ARM_CHANNELS = 2;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam longint unsigned MAIN_DELAY_SEC = 29;
  localparam longint unsigned BYPASS_DELAY_MIN = 8;
  localparam longint unsigned SEC_PER_MIN = 60;
  localparam longint unsigned MAIN_DELAY_CYC = MAIN_DELAY_SEC * CLK_HZ;
  localparam longint unsigned BYPASS_DELAY_CYC = BYPASS_DELAY_MIN * SEC_PER_MIN * CLK_HZ;
  localparam int unsigned TIMER_W = 36;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_OFF  = 2'h0,
    SEL_AUTO = 2'h1,
    SEL_OPEN = 2'h2
  } selector_e;

  // All operator and sensor inputs, travelling together through the synchroniser.
  typedef struct packed {
    logic [CHANNELS-1:0] dw_trip;
    logic [CHANNELS-1:0] low_low_level_trip;
    logic [LPF_PUMPS-1:0] low_pressure_flooder_run;
    logic [HPF_PUMPS-1:0] high_pressure_flooder_run;
    logic anticipated_transient_permissive;
    logic transient_manual_inhibit;
    logic division_inhibit;
    logic manual_reset;
    logic [ARM_CHANNELS-1:0] arm_collar;
    logic [ARM_CHANNELS-1:0] push_button;
    logic [VALVES-1:0][1:0] selector;
  } pins_s;

  // True when at least VOTE_MIN of the channel trips are asserted.
  function automatic logic two_of_four(input logic [CHANNELS-1:0] trips);
    int unsigned sum;
    sum = 0;
    for (int i = 0; i < CHANNELS; i++) begin
      sum = sum + int'(trips[i]);
    end
    return (sum >= VOTE_MIN);
  endfunction : two_of_four

endpackage : depress_pkg

`default_nettype wire

// File: pin_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Each bit is an independent slow level.
// Notes: The first stage is read only by the second stage.
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ---------------------------------------------------------------------------
  // Stages
  // ---------------------------------------------------------------------------
  // Multi-bit skew is not guarded here; of these bits only the channel trips are voted later, and none is debounced.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pin_sync

`default_nettype wire

// File: delay_timer.sv
// Purpose: Restartable delay timer with a parameter terminal count.
// Assumes: run_in is a level from the same clock domain.
// Notes: Any drop of run_in returns the count to zero at once.
`default_nettype none

module delay_timer #(
  parameter int unsigned WIDTH = 36,
  parameter logic [63:0] TERMINAL = 64'h0000_0000_0000_0010
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic running_out,
  output logic done_out
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic [WIDTH-1:0] term_cnt;

  assign term_cnt = TERMINAL[WIDTH-1:0];

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // Counting saturates at the terminal so that done stays while run holds.
  always_comb begin
    if (!run_in) begin
      count_nxt = '0;
    end else if (count_r == term_cnt) begin
      count_nxt = count_r;
    end else begin
      count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Done rises after exactly TERMINAL cycles of continuous run.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_r <= '0;
      running_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      count_r <= count_nxt;
      running_out <= run_in && (count_nxt != term_cnt);
      done_out <= run_in && (count_nxt == term_cnt);
    end
  end

endmodule : delay_timer

`default_nettype wire

// File: depress_division.sv
// Purpose: One division of automatic depressurization initiation logic.
// Assumes: All inputs are asynchronous pins; one 125 MHz clock.
// Notes: The pilot outputs of both divisions are ORed at the valve, outside this block.
`default_nettype none

module depress_division
  import depress_pkg::*;
#(
  parameter logic [63:0] MAIN_DELAY_CYCLES = 64'(depress_pkg::MAIN_DELAY_CYC),
  parameter logic [63:0] BYPASS_DELAY_CYCLES = 64'(depress_pkg::BYPASS_DELAY_CYC)
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [depress_pkg::CHANNELS-1:0] dw_trip_in,
  input wire logic [depress_pkg::CHANNELS-1:0] low_low_level_trip_in,
  input wire logic [depress_pkg::LPF_PUMPS-1:0] low_pressure_flooder_run_in,
  input wire logic [depress_pkg::HPF_PUMPS-1:0] high_pressure_flooder_run_in,
  input wire logic anticipated_transient_permissive_in,
  input wire logic transient_manual_inhibit_in,
  input wire logic division_inhibit_in,
  input wire logic manual_reset_in,
  input wire logic [depress_pkg::ARM_CHANNELS-1:0] arm_collar_in,
  input wire logic [depress_pkg::ARM_CHANNELS-1:0] push_button_in,
  input wire logic [2*depress_pkg::VALVES-1:0] selector_in,
  output logic [depress_pkg::VALVES-1:0] pilot_out,
  output logic [depress_pkg::VALVES-1:0] manual_open_out,
  output logic [depress_pkg::VALVES-1:0] pilot_lamp_out,
  output logic dw_trip_ann_out,
  output logic low_low_level_ann_out,
  output logic timing_ann_out,
  output logic inhibit_ann_out,
  output logic armed_ann_out,
  output logic initiated_out
);

  import depress_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  pins_s pins_raw;
  pins_s pins;

  // Every pin enters the clock domain through two flip-flops before use.
  always_comb begin
    pins_raw.dw_trip = dw_trip_in;
    pins_raw.low_low_level_trip = low_low_level_trip_in;
    pins_raw.low_pressure_flooder_run = low_pressure_flooder_run_in;
    pins_raw.high_pressure_flooder_run = high_pressure_flooder_run_in;
    pins_raw.anticipated_transient_permissive = anticipated_transient_permissive_in;
    pins_raw.transient_manual_inhibit = transient_manual_inhibit_in;
    pins_raw.division_inhibit = division_inhibit_in;
    pins_raw.manual_reset = manual_reset_in;
    pins_raw.arm_collar = arm_collar_in;
    pins_raw.push_button = push_button_in;
    pins_raw.selector = selector_in;
  end

  pin_sync #(
    .WIDTH($bits(pins_s))
  ) u_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // ---------------------------------------------------------------------------
  // Voting and permissives
  // ---------------------------------------------------------------------------
  logic dw_vote;
  logic ll_vote;
  logic pump_perm;
  logic transient_ok;
  logic armed;
  logic manual_fire;
  logic auto_fire;
  logic reset_allowed;
  logic [VALVES-1:0] open_vec;

  // Both parameters vote on the current channel trips.
  assign dw_vote = two_of_four(pins.dw_trip);
  assign ll_vote = two_of_four(pins.low_low_level_trip);

  // Any single running pump is enough to show makeup is available.
  assign pump_perm = (|pins.low_pressure_flooder_run)
                   | (|pins.high_pressure_flooder_run);

  // Low level and the power monitor permissive must coincide, and no operator inhibit.
  assign transient_ok = ll_vote && pins.anticipated_transient_permissive
                      && !pins.transient_manual_inhibit;

  // Arming needs both collars of this division turned.
  assign armed = &pins.arm_collar;

  // Manual fire bypasses the timers but still needs a running pump.
  assign manual_fire = armed && (&pins.push_button) && pump_perm;

  // A reset attempt is void while both coincidences persist.
  assign reset_allowed = pins.manual_reset && !(dw_vote && ll_vote);

  // ---------------------------------------------------------------------------
  // Parameter seal-in latches
  // ---------------------------------------------------------------------------
  logic dw_latch_r;
  logic ll_latch_r;

  // Set wins over reset, so a parameter still tripped can never be cleared.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dw_latch_r <= 1'b0;
    end else if (dw_vote) begin
      dw_latch_r <= 1'b1;
    end else if (reset_allowed) begin
      dw_latch_r <= 1'b0;
    end
  end

  // The level latch is independent of the drywell latch.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ll_latch_r <= 1'b0;
    end else if (ll_vote) begin
      ll_latch_r <= 1'b1;
    end else if (reset_allowed) begin
      ll_latch_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Delay timers
  // ---------------------------------------------------------------------------
  logic bypass_run;
  logic main_run;
  logic bypass_running;
  logic bypass_done;
  logic main_running;
  logic main_done;

  // Timing follows the live level vote, not the latch, so a level recovery
  // zeroes the count and every new crossing starts from zero. The reset
  // pushbutton reaches only the main timer, by clearing the drywell latch.
  assign bypass_run = ll_vote;
  // The main timer waits for sealed-in drywell pressure or an expired bypass.
  assign main_run = ll_vote && (dw_latch_r || bypass_done);

  delay_timer #(
    .WIDTH(TIMER_W),
    .TERMINAL(BYPASS_DELAY_CYCLES)
  ) u_bypass_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(bypass_run),
    .running_out(bypass_running),
    .done_out(bypass_done)
  );

  delay_timer #(
    .WIDTH(TIMER_W),
    .TERMINAL(MAIN_DELAY_CYCLES)
  ) u_main_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(main_run),
    .running_out(main_running),
    .done_out(main_done)
  );

  // ---------------------------------------------------------------------------
  // Initiation latch
  // ---------------------------------------------------------------------------
  logic init_r;
  logic init_nxt;

  // The keylock inhibit only blocks a division that has not yet fired; once
  // fired it is ignored so it can never reclose valves already opened.
  assign auto_fire = main_done && main_run && pump_perm && transient_ok
                   && (!pins.division_inhibit || init_r);

  // Fire wins over reset; reset is void while both coincidences remain.
  always_comb begin
    if (auto_fire || manual_fire) begin
      init_nxt = 1'b1;
    end else if (reset_allowed) begin
      init_nxt = 1'b0;
    end else begin
      init_nxt = init_r;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_r <= 1'b0;
    end else begin
      init_r <= init_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Valve outputs
  // ---------------------------------------------------------------------------
  // The selector OPEN position drives the non-division pilot of its own valve.
  generate
    for (genvar v = 0; v < VALVES; v++) begin : g_sel
      assign open_vec[v] = (pins.selector[v] == SEL_OPEN);
    end
  endgenerate

  // Outputs are registered; the division pilot goes to every valve together.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pilot_out <= '0;
      manual_open_out <= '0;
      pilot_lamp_out <= '0;
    end else begin
      pilot_out <= {VALVES{init_nxt}};
      manual_open_out <= open_vec;
      pilot_lamp_out <= {VALVES{init_nxt}} | open_vec;
    end
  end

  // ---------------------------------------------------------------------------
  // Annunciators
  // ---------------------------------------------------------------------------
  // The two trip annunciators follow the latched state so an alarm outlives a brief trip.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dw_trip_ann_out <= 1'b0;
      low_low_level_ann_out <= 1'b0;
      timing_ann_out <= 1'b0;
      inhibit_ann_out <= 1'b0;
      armed_ann_out <= 1'b0;
      initiated_out <= 1'b0;
    end else begin
      dw_trip_ann_out <= dw_latch_r;
      low_low_level_ann_out <= ll_latch_r;
      timing_ann_out <= bypass_running || main_running;
      inhibit_ann_out <= pins.division_inhibit;
      armed_ann_out <= armed;
      initiated_out <= init_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_armed_press;
    armed ##0 (&pins.push_button) ##0 pump_perm;
  endsequence

  sequence s_level_drop;
    $fell(ll_vote);
  endsequence

  property p_vote_latch;
    @(posedge core_clk_in) disable iff (rst_in)
      dw_vote |=> dw_latch_r ##1 dw_trip_ann_out;
  endproperty
  a_vote_latch: assert property (p_vote_latch)
    else $error("drywell vote did not latch and annunciate");

  property p_dw_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      dw_latch_r && !pins.manual_reset |=> dw_latch_r;
  endproperty
  a_dw_hold: assert property (p_dw_hold)
    else $error("drywell latch cleared without reset");

  property p_reset_void;
    @(posedge core_clk_in) disable iff (rst_in)
      dw_vote && ll_vote && pins.manual_reset |=> dw_latch_r && ll_latch_r;
  endproperty
  a_reset_void: assert property (p_reset_void)
    else $error("reset acted while both votes present");

  property p_level_abort;
    @(posedge core_clk_in) disable iff (rst_in)
      s_level_drop |=> !main_done && !bypass_done ##1 !timing_ann_out;
  endproperty
  a_level_abort: assert property (p_level_abort)
    else $error("timer survived level recovery");

  property p_timing_ann;
    @(posedge core_clk_in) disable iff (rst_in)
      (bypass_running || main_running) |=> timing_ann_out;
  endproperty
  a_timing_ann: assert property (p_timing_ann)
    else $error("timing annunciator missing");

  property p_no_pump_no_fire;
    @(posedge core_clk_in) disable iff (rst_in)
      !pump_perm && !init_r |=> !init_r;
  endproperty
  a_no_pump_no_fire: assert property (p_no_pump_no_fire)
    else $error("fired without pump permissive");

  property p_transient_block;
    @(posedge core_clk_in) disable iff (rst_in)
      !init_r && !manual_fire && !transient_ok |=> !init_r;
  endproperty
  a_transient_block: assert property (p_transient_block)
    else $error("auto fire without transient permissive");

  property p_inhibit_ignored;
    @(posedge core_clk_in) disable iff (rst_in)
      init_r && pins.division_inhibit && !pins.manual_reset |=> init_r && pilot_out[0];
  endproperty
  a_inhibit_ignored: assert property (p_inhibit_ignored)
    else $error("inhibit closed an initiated division");

  property p_inhibit_ann;
    @(posedge core_clk_in) disable iff (rst_in)
      pins.division_inhibit [*2] |-> inhibit_ann_out;
  endproperty
  a_inhibit_ann: assert property (p_inhibit_ann)
    else $error("inhibit not annunciated");

  property p_manual_fire;
    @(posedge core_clk_in) disable iff (rst_in)
      s_armed_press |=> (&pilot_out) && (&pilot_lamp_out) && armed_ann_out;
  endproperty
  a_manual_fire: assert property (p_manual_fire)
    else $error("armed manual fire did not energize pilots");

  property p_selector_open;
    @(posedge core_clk_in) disable iff (rst_in)
      open_vec[0] |=> manual_open_out[0] && pilot_lamp_out[0];
  endproperty
  a_selector_open: assert property (p_selector_open)
    else $error("selector open did not open valve");

  property p_main_needs_level;
    @(posedge core_clk_in) disable iff (rst_in)
      !ll_vote && !init_r && !manual_fire |=> !init_r;
  endproperty
  a_main_needs_level: assert property (p_main_needs_level)
    else $error("auto fire without low level vote");

endmodule : depress_division

`default_nettype wire

// File: panel_model.sv
// Purpose: Panel and valve model that faces one division.
// Assumes: The bench sets the pin bundle just after a clock edge.
// Notes: A valve opens on the division pilot or on its own open position.
`default_nettype none

module panel_model
  import depress_pkg::*;
(
  input wire depress_pkg::pins_s pins_in,
  input wire logic [depress_pkg::VALVES-1:0] pilot_in,
  input wire logic [depress_pkg::VALVES-1:0] manual_open_in,
  output depress_pkg::pins_s pins_out,
  output logic [depress_pkg::VALVES-1:0] valve_open_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Panel switches and sensor trips
  // ---------------------------------------------------------------
  // Operators arm collars before pressing buttons; the bench orders it.
  assign pins_out = pins_in;

  // ---------------------------------------------------------------
  // Valve gas pistons
  // ---------------------------------------------------------------
  // Either pilot alone opens a valve, so no vote is taken here.
  assign valve_open_out = pilot_in | manual_open_in;

endmodule : panel_model

`default_nettype wire

// File: depress_division_tb.sv
// Purpose: Self-checking bench for one depressurization division.
// Assumes: Timers are shortened to 20 and 50 cycles.
// Notes: Pins change 1 ns after a rising edge.
`default_nettype none

module depress_division_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import depress_pkg::*;

  localparam int MAIN = 32'h14;
  localparam int BYP = 32'h32;
  logic core_clk;
  logic rst;
  pins_s pins;
  pins_s pins_drv;
  pins_s p;
  logic [VALVES-1:0] pilot, man_open, lamp, valve_open;
  logic dw_ann, ll_ann, tim_ann, inh_ann, arm_ann, init;
  int miscompares = 0;
  int checks = 0;
  int n;
  string cur_test = "idle";

  // Free-running 125 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  panel_model u_panel_model (.pins_in(pins), .pilot_in(pilot), .manual_open_in(man_open),
    .pins_out(pins_drv), .valve_open_out(valve_open));

  depress_division #(.MAIN_DELAY_CYCLES(64'h14), .BYPASS_DELAY_CYCLES(64'h32))
  u_depress_division (.core_clk_in(core_clk), .rst_in(rst),
    .dw_trip_in(pins_drv.dw_trip), .low_low_level_trip_in(pins_drv.low_low_level_trip),
    .low_pressure_flooder_run_in(pins_drv.low_pressure_flooder_run),
    .high_pressure_flooder_run_in(pins_drv.high_pressure_flooder_run),
    .anticipated_transient_permissive_in(pins_drv.anticipated_transient_permissive),
    .transient_manual_inhibit_in(pins_drv.transient_manual_inhibit),
    .division_inhibit_in(pins_drv.division_inhibit),
    .manual_reset_in(pins_drv.manual_reset), .arm_collar_in(pins_drv.arm_collar),
    .push_button_in(pins_drv.push_button), .selector_in(pins_drv.selector),
    .pilot_out(pilot), .manual_open_out(man_open), .pilot_lamp_out(lamp),
    .dw_trip_ann_out(dw_ann), .low_low_level_ann_out(ll_ann), .timing_ann_out(tim_ann),
    .inhibit_ann_out(inh_ann), .armed_ann_out(arm_ann), .initiated_out(init));

  // ---------------------------------------------------------------
  // Helper tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Each step lands 1 ns past the edge, so outputs have settled.
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk_vec

  // A short reset between tests keeps latches from leaking across.
  task automatic new_run(input string name);
    $display("test %s done", cur_test);
    cur_test = name;
    pins = '0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    p = '0;
  endtask : new_run

  // Bounded wait for the pilots; running out ends the run.
  task automatic wait_fire(input int lim, output int cyc);
    cyc = 0;
    while (pilot !== 8'hFF && cyc < lim) begin
      step(1);
      cyc++;
    end
    chk_vec(pilot, 8'hFF, "pilots never fired");
    if (pilot !== 8'hFF) begin
      report_and_stop();
    end
  endtask : wait_fire

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pins = '0;
    p = '0;
    step(5);
    rst = 1'b0;
    step(3);
    chk_vec(valve_open, 8'h00, "idle valves"); // Idle.
    chk_bit(tim_ann, 1'b0, "idle timing"); // Idle.
    // Manual path, once with each of the five pumps running alone.
    for (int i = 0; i < 5; i++) begin
      new_run("manual");
      p.arm_collar = 2'h3;
      pins = p;
      step(4);
      chk_bit(arm_ann, 1'b1, "armed"); // Armed.
      p.push_button = 2'h3;
      pins = p;
      step(5);
      chk_vec(pilot, 8'h00, "fired without pump"); // No pump.
      {p.high_pressure_flooder_run, p.low_pressure_flooder_run} = 5'h01 << i;
      pins = p;
      step(4);
      chk_vec(pilot, 8'hFF, "manual fire"); // Fired.
      chk_vec(lamp, 8'hFF, "lamps"); // Lit.
    end
    // Drywell and level together, with reset and inhibit after firing.
    new_run("drywell");
    p.dw_trip = 4'h3;
    p.low_low_level_trip = 4'h5;
    p.low_pressure_flooder_run = 3'h1;
    p.anticipated_transient_permissive = 1'b1;
    pins = p;
    step(5);
    chk_bit(dw_ann, 1'b1, "dw latch"); // Latched.
    chk_bit(ll_ann, 1'b1, "level latch"); // Latched.
    chk_bit(tim_ann, 1'b1, "timing"); // Timing.
    wait_fire(MAIN + 3, n); // Fired.
    chk_bit(logic'(n + 5 >= MAIN + 2), 1'b1, "main delay short"); // Delay.
    p.division_inhibit = 1'b1;
    p.manual_reset = 1'b1;
    pins = p;
    step(5);
    chk_bit(inh_ann, 1'b1, "inhibit ann"); // Shown.
    chk_vec(valve_open, 8'hFF, "valves closed"); // Held.
    chk_bit(dw_ann, 1'b1, "reset obeyed"); // Refused.
    p.manual_reset = 1'b0;
    p.dw_trip = 4'h0;
    pins = p;
    step(5);
    chk_bit(dw_ann, 1'b1, "seal-in lost"); // Sealed.
    p.low_low_level_trip = 4'h0;
    p.division_inhibit = 1'b0;
    p.manual_reset = 1'b1;
    pins = p;
    step(6);
    chk_bit(dw_ann, 1'b0, "dw not cleared"); // Cleared.
    chk_bit(init, 1'b0, "init not cleared"); // Cleared.
    // Level dip in mid-timing, with reset held before it.
    new_run("dip");
    p.dw_trip = 4'hC;
    p.low_low_level_trip = 4'h3;
    p.high_pressure_flooder_run = 2'h2;
    p.anticipated_transient_permissive = 1'b1;
    p.manual_reset = 1'b1;
    pins = p;
    step(12);
    chk_bit(tim_ann, 1'b1, "timer disturbed"); // Running.
    p.manual_reset = 1'b0;
    p.low_low_level_trip = 4'h1;
    pins = p;
    step(4);
    chk_bit(tim_ann, 1'b0, "timer kept"); // Zeroed.
    chk_vec(pilot, 8'h00, "fired on dip"); // Aborted.
    p.low_low_level_trip = 4'h3;
    pins = p;
    step(1);
    wait_fire(MAIN + 8, n); // Fired.
    chk_bit(logic'(n + 1 >= MAIN + 2), 1'b1, "timer resumed"); // Restart.
    // Low level alone runs the bypass timer first.
    new_run("bypass");
    p.low_low_level_trip = 4'h9;
    p.low_pressure_flooder_run = 3'h4;
    p.anticipated_transient_permissive = 1'b1;
    pins = p;
    step(BYP);
    chk_vec(pilot, 8'h00, "bypass skipped"); // Waiting.
    chk_bit(tim_ann, 1'b1, "bypass timing"); // Timing.
    wait_fire(MAIN + 12, n); // Fired.
    chk_bit(logic'(n >= MAIN + 2), 1'b1, "bypass short"); // Order.
    // Each blocker alone must stop automatic firing.
    for (int k = 0; k < 4; k++) begin
      new_run("blocked");
      p.dw_trip = 4'hF;
      p.low_low_level_trip = 4'h6;
      p.low_pressure_flooder_run = 3'h2;
      p.anticipated_transient_permissive = (k != 0);
      p.transient_manual_inhibit = (k == 1);
      p.division_inhibit = (k == 3);
      if (k == 2) begin
        p.low_pressure_flooder_run = 3'h0;
      end
      pins = p;
      step(MAIN + 10);
      chk_vec(pilot, 8'h00, "blocked fire"); // Blocked.
    end
    // One channel per parameter is not a vote.
    new_run("vote");
    p.dw_trip = 4'h8;
    p.low_low_level_trip = 4'h2;
    p.low_pressure_flooder_run = 3'h1;
    p.anticipated_transient_permissive = 1'b1;
    pins = p;
    step(BYP + MAIN + 10);
    chk_bit(dw_ann | ll_ann, 1'b0, "single channel trip"); // Vote.
    chk_vec(pilot, 8'h00, "single channel fire"); // Vote.
    // Every selector code across the valves.
    new_run("selector");
    // Valve 0 takes the open position so the per-valve assertion is exercised.
    for (int v = 0; v < 8; v++) p.selector[v] = 2'((v + 2) % 4);
    pins = p;
    step(4);
    chk_vec(man_open, 8'h11, "open positions"); // Open.
    chk_vec(lamp, 8'h11, "open lamps"); // Lit.
    chk_vec(pilot, 8'h00, "division pilot"); // Idle.
    new_run("end");
    report_and_stop();
  end

endmodule : depress_division_tb

`default_nettype wire
